// file: hw/tsn_pkg.sv
// Package for the temperature sensor two-wire target: constants, states, carriers.
// Assumes a single system clock at 10 MHz; the bus logic runs on its own clock.
package tsn_pkg;

    localparam int          CLK_HZ          = 10_000_000;
    localparam int          COMMIT_MS       = 10;
    localparam int          COMMIT_CYCLES   = CLK_HZ / 1000 * COMMIT_MS;
    localparam int          CONV_CYCLES     = 1000;

    // Type code in the top bits of the control byte; the value is arbitrary
    localparam logic [3:0]  TYPE_CODE       = 4'h6;
    localparam logic [7:0]  CMD_READ_TEMP   = 8'haa;
    localparam logic [7:0]  CMD_ACCESS_CFG  = 8'hac;
    localparam logic [7:0]  CMD_START_CONV  = 8'hee;
    localparam logic [7:0]  CMD_STOP_CONV   = 8'h22;

    localparam int          CFG_DONE_POS    = 7;
    localparam int          CFG_SINGLE_POS  = 0;
    localparam logic [5:0]  CFG_FIXED       = 6'h05;
    localparam logic        CFG_SINGLE_RST  = 1'b0;
    localparam logic [15:0] TEMP_RST        = 16'h0000;
    localparam int          TEMP_ZERO_BITS  = 4;

    typedef enum logic [4:0] {
        LNK_IDLE = 5'b00001,
        LNK_RECV = 5'b00010,
        LNK_RACK = 5'b00100,
        LNK_SEND = 5'b01000,
        LNK_TACK = 5'b10000
    } tsn_link_state_type;

    // Command event from the link side, carried across as a toggle plus stable data
    typedef struct packed {
        logic       start_conv;
        logic       stop_conv;
        logic       cfg_write;
        logic [7:0] cfg_data;
    } tsn_cmd_type;

endpackage

// file: hw/tsn_sync.sv
// Two flip-flop level synchroniser, parameterised in width.
// Assumes the input is a level or a slowly changing toggle from another domain.
`timescale 1ns/1ns
module tsn_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// file: hw/tsn_target.sv
// Two-wire target front end of a temperature sensor with result and config registers.
// Assumes the bus controller drives SCL (used as the link clock) and all START/STOP.
`timescale 1ns/1ns

module tsn_target
    import tsn_pkg::*;
#(
    parameter int COMMIT_COUNT = tsn_pkg::COMMIT_CYCLES,
    parameter int CONV_COUNT   = tsn_pkg::CONV_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        scl_clk,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        select_pin_hi,
    input  wire logic        select_pin_mid,
    input  wire logic        select_pin_lo,
    input  wire logic [11:0] adc_sample,
    output logic             conv_active,
    output logic             commit_busy
);
    import tsn_pkg::*;

    // System domain: result, configuration, conversion engine
    logic [15:0]         temperature_result;
    logic                single_conversion_select;
    logic                done;
    logic                running;
    logic                halt_pending;
    logic [31:0]         conv_cnt;
    logic [31:0]         commit_cnt;
    logic                cmd_tgl_sys;
    logic                cmd_tgl_seen;
    tsn_cmd_type         cmd_link;
    tsn_cmd_type         cmd_sys;
    logic [7:0]          operation_config_status;

    // Link domain
    tsn_link_state_type  state;
    logic [2:0]          bit_cnt;
    logic [7:0]          shreg;
    logic [7:0]          tx_byte;
    logic                first_byte;
    logic                second_byte;
    logic                is_read;
    logic [7:0]          command;
    logic                temp_lsb_next;
    logic                cmd_tgl_link;
    logic                sda_hold;
    logic                start_tgl;
    logic                stop_tgl;
    logic                start_tgl_seen;
    logic                stop_tgl_seen;
    logic [15:0]         temp_link;
    logic [7:0]          cfg_link;

    // Result stored with the four unused low bits forced to zero (12-bit value left-justified in the top bits)
    wire  [15:0] sample_word = {adc_sample, {TEMP_ZERO_BITS{1'b0}}};
    assign operation_config_status = {done, CFG_FIXED, single_conversion_select};

    wire         conv_end     = running && (conv_cnt == 32'(CONV_COUNT - 1));
    wire         cmd_new      = cmd_tgl_sys != cmd_tgl_seen;
    wire         start_req    = cmd_new && cmd_sys.start_conv;
    wire         stop_req     = cmd_new && cmd_sys.stop_conv;
    wire         cfg_req      = cmd_new && cmd_sys.cfg_write;
    wire         restart      = conv_end && !single_conversion_select && !halt_pending && !stop_req;

    assign conv_active = running;
    assign commit_busy = commit_cnt != 32'd0;

    tsn_sync #(.WIDTH(1)) u_cmd_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (cmd_tgl_link),
        .sync_out (cmd_tgl_sys)
    );

    // Command data is stable long before the toggle lands, so sampling it on arrival is safe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_tgl_seen <= 1'b0;
            cmd_sys      <= '0;
        end else begin
            cmd_tgl_seen <= cmd_tgl_sys;
            cmd_sys      <= cmd_link;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            running <= 1'b0;
            conv_cnt <= '0;
        end else if (start_req && !running) begin
            running  <= 1'b1;
            conv_cnt <= '0;
        end else if (conv_end) begin
            running  <= restart;
            conv_cnt <= '0;
        end else if (running) begin
            conv_cnt <= conv_cnt + 32'd1;
        end
    end

    // Halt lets the running measurement finish, then stays idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            halt_pending <= 1'b0;
        end else if (stop_req) begin
            halt_pending <= running;
        end else if (conv_end || start_req) begin
            halt_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done               <= 1'b1;
            temperature_result <= TEMP_RST;
        end else if (conv_end) begin
            done               <= !restart;
            temperature_result <= sample_word;
        end else if (start_req && !running) begin
            done <= 1'b0;
        end
    end

    // No nonvolatile cell here: the bit keeps its value while powered and resets to the shipped default
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            single_conversion_select <= CFG_SINGLE_RST;
            commit_cnt               <= '0;
        end else if (cfg_req && !commit_busy) begin
            single_conversion_select <= cmd_sys.cfg_data[CFG_SINGLE_POS];
            commit_cnt               <= 32'(COMMIT_COUNT);
        end else if (commit_busy) begin
            commit_cnt <= commit_cnt - 32'd1;
        end
    end

    // Link domain: registers captured through a two-stage crossing of each bit
    logic [15:0] temp_sync;
    logic [7:0]  cfg_sync;
    tsn_sync #(.WIDTH(24)) u_reg_sync (
        .clk      (scl_clk),
        .rst_b    (rst_b),
        .async_in ({temperature_result, operation_config_status}),
        .sync_out ({temp_sync, cfg_sync})
    );

    logic [23:0] reg_sync_prev;
    wire         reg_steady = {temp_sync, cfg_sync} == reg_sync_prev;

    // SCL stops between frames, so the copy is refreshed only while the link is idle or receiving the control byte
    // A word is taken only once two successive samples agree, so a half-updated value is never used
    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_sync_prev <= '0;
            temp_link     <= TEMP_RST;
            cfg_link      <= '0;
        end else begin
            reg_sync_prev <= {temp_sync, cfg_sync};
            if ((state == LNK_IDLE || first_byte) && reg_steady) begin
                temp_link <= temp_sync;
                cfg_link  <= cfg_sync;
            end
        end
    end

    // Strap pins cross on the link clock; they settle within the first two bits of a frame
    logic [2:0]  sel_sync;
    tsn_sync #(.WIDTH(3)) u_sel_sync (
        .clk      (scl_clk),
        .rst_b    (rst_b),
        .async_in ({select_pin_hi, select_pin_mid, select_pin_lo}),
        .sync_out (sel_sync)
    );

    // START and STOP: data edges while SCL is high, seen as toggles on the data line's edges
    always_ff @(negedge sda_in or negedge rst_b) begin
        if (!rst_b) begin
            start_tgl <= 1'b0;
        end else if (scl_clk) begin
            start_tgl <= !start_tgl;
        end
    end

    always_ff @(posedge sda_in or negedge rst_b) begin
        if (!rst_b) begin
            stop_tgl <= 1'b0;
        end else if (scl_clk) begin
            stop_tgl <= !stop_tgl;
        end
    end

    // A STOP seen in LNK_RECV returns the link to idle only at the next SCL rise; the data line is released meanwhile
    wire start_seen = start_tgl != start_tgl_seen;
    wire stop_seen  = stop_tgl != stop_tgl_seen;
    wire [7:0] rx_full  = {shreg[6:0], sda_in};
    wire       ctrl_hit = (rx_full[7:1] == {TYPE_CODE, sel_sync});

    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            state          <= LNK_IDLE;
            bit_cnt        <= '0;
            shreg          <= '0;
            first_byte     <= 1'b0;
            second_byte    <= 1'b0;
            is_read        <= 1'b0;
            command        <= '0;
            temp_lsb_next  <= 1'b0;
            start_tgl_seen <= 1'b0;
            stop_tgl_seen  <= 1'b0;
        end else begin
            start_tgl_seen <= start_tgl;
            stop_tgl_seen  <= stop_tgl;
            if (start_seen) begin
                // Repeated START restarts the frame without going through idle
                state      <= LNK_RECV;
                bit_cnt    <= 3'd1;
                shreg      <= {7'd0, sda_in};
                first_byte <= 1'b1;
            end else begin
                unique case (state)
                    LNK_IDLE: begin
                        bit_cnt <= '0;
                    end
                    LNK_RECV: begin
                        shreg   <= rx_full;
                        bit_cnt <= bit_cnt + 3'd1;
                        if (stop_seen) begin
                            state <= LNK_IDLE;
                        end else if (bit_cnt == 3'd7) begin
                            if (first_byte && !ctrl_hit) begin
                                state <= LNK_IDLE;
                            end else begin
                                state <= LNK_RACK;
                            end
                        end
                    end
                    LNK_RACK: begin
                        bit_cnt <= '0;
                        if (first_byte) begin
                            first_byte    <= 1'b0;
                            second_byte   <= !shreg[0];
                            is_read       <= shreg[0];
                            temp_lsb_next <= 1'b0;
                            state         <= shreg[0] ? LNK_SEND : LNK_RECV;
                        end else if (second_byte) begin
                            second_byte <= 1'b0;
                            command     <= shreg;
                            state       <= LNK_RECV;
                        end else begin
                            state <= LNK_RECV;
                        end
                    end
                    LNK_SEND: begin
                        bit_cnt <= bit_cnt + 3'd1;
                        if (bit_cnt == 3'd7) begin
                            state <= LNK_TACK;
                        end
                    end
                    LNK_TACK: begin
                        bit_cnt <= '0;
                        // Controller's missing acknowledge ends the read
                        if (sda_in) begin
                            state <= LNK_IDLE;
                        end else begin
                            state         <= LNK_SEND;
                            temp_lsb_next <= !temp_lsb_next;
                        end
                    end
                    default: state <= LNK_IDLE;
                endcase
            end
        end
    end

    // Start and stop act at the command byte's acknowledge; ACh sends a config write for every byte written after it, stored only if no commit is busy
    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_link     <= '0;
            cmd_tgl_link <= 1'b0;
        end else if (state == LNK_RACK && !first_byte && !start_seen) begin
            if (second_byte && (shreg == CMD_START_CONV || shreg == CMD_STOP_CONV)) begin
                cmd_link     <= '{start_conv: shreg == CMD_START_CONV,
                                  stop_conv:  shreg == CMD_STOP_CONV,
                                  cfg_write:  1'b0,
                                  cfg_data:   8'h00};
                cmd_tgl_link <= !cmd_tgl_link;
            end else if (!second_byte && !is_read && command == CMD_ACCESS_CFG) begin
                cmd_link     <= '{start_conv: 1'b0, stop_conv: 1'b0, cfg_write: 1'b1, cfg_data: shreg};
                cmd_tgl_link <= !cmd_tgl_link;
            end
        end
    end

    // Read data: result MSB then LSB for AAh, config byte for ACh
    always_comb begin
        if (command == CMD_ACCESS_CFG) begin
            tx_byte = cfg_link;
        end else if (temp_lsb_next) begin
            tx_byte = temp_link[7:0];
        end else begin
            tx_byte = temp_link[15:8];
        end
    end

    // Data changes on SCL falling so it is stable across the high phase
    wire next_low = (state == LNK_RACK && !start_seen)
                  || (state == LNK_SEND && !tx_byte[~bit_cnt]);

    always_ff @(negedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_hold <= 1'b0;
        end else begin
            sda_hold <= next_low && !stop_seen;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = sda_hold;
endmodule

// file: verification/tsn_target_properties.sv
// Port-level concurrent checks for the sensor target, bound into every instance.
// Assumes SCL stands high between frames and stays high under 300 ns inside one.
`timescale 1ns/1ns
module tsn_target_properties #(
    parameter int COMMIT_COUNT = 20,
    parameter int CONV_COUNT   = 1000
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        scl_clk,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        select_pin_hi,
    input wire logic        select_pin_mid,
    input wire logic        select_pin_lo,
    input wire logic [11:0] adc_sample,
    input wire logic        conv_active,
    input wire logic        commit_busy
);
    int   busy_cnt;
    int   conv_cnt;
    logic oe_at_rise;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt <= 0;
            conv_cnt <= 0;
        end else begin
            busy_cnt <= commit_busy ? busy_cnt + 1 : 0;
            conv_cnt <= conv_active ? conv_cnt + 1 : 0;
        end
    end

    // Drive level captured at SCL rise, compared again at SCL fall
    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) oe_at_rise <= 1'b0;
        else oe_at_rise <= sda_oe;
    end

    a_sda_out_zero: assert property (@(posedge clk) disable iff (!rst_b) sda_out == 1'b0)
        else $error("sda_out driven high");
    a_oe_stable_high: assert property (@(negedge scl_clk) disable iff (!rst_b) sda_oe == oe_at_rise)
        else $error("sda_oe changed while SCL high");
    a_reset_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> !sda_oe && !conv_active && !commit_busy)
        else $error("outputs active right after reset");
    a_idle_release: assert property (@(posedge clk) disable iff (!rst_b) scl_clk [*4] |-> !sda_oe)
        else $error("SDA held low on idle bus");
    a_commit_len: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(commit_busy) |-> busy_cnt >= COMMIT_COUNT - 1 && busy_cnt <= COMMIT_COUNT + 2)
        else $error("config commit length wrong");
    a_commit_after_stop: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(commit_busy) |-> scl_clk && $past(scl_clk))
        else $error("commit began inside a frame");
    a_commit_no_restart: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(commit_busy) |=> !commit_busy [*3])
        else $error("commit restarted without a write");
    a_conv_len: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(conv_active) |-> conv_cnt >= CONV_COUNT - 1)
        else $error("conversion cut short");
endmodule

bind tsn_target tsn_target_properties #(.COMMIT_COUNT(COMMIT_COUNT), .CONV_COUNT(CONV_COUNT)) u_props (
    .clk(clk), .rst_b(rst_b), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .select_pin_hi(select_pin_hi), .select_pin_mid(select_pin_mid), .select_pin_lo(select_pin_lo),
    .adc_sample(adc_sample), .conv_active(conv_active), .commit_busy(commit_busy));

// file: verification/tsn_master_model.sv
// Two-wire bus controller model: SCL, START, STOP, bytes and acknowledges.
// Assumes SDA is pulled up outside and resolved from both open-drain drivers.
`timescale 1ns/1ns
module tsn_master_model (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    localparam int QTR = 20;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Data moves only while SCL is low; the clock stands still between frames
    task automatic bit_slot(input logic b, output logic s);
        sda_low = ~b;
        #QTR scl = 1'b1;
        #QTR s = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    task automatic start();
        sda_low = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b1;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // Returns the SDA level seen before STOP, to show the target let go
    task automatic stop(output logic rel);
        rel = sda;
        sda_low = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b0;
        #QTR;
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
        bit_slot(1'b1, s);
        ack = ~s;
    endtask

    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
        bit_slot(~ack, s);
    endtask
endmodule

// file: verification/tsn_target_test.sv
// Self-checking bench for the sensor target with a bus controller model.
// Assumes SDA is pulled up here; expectations come from a small register model.
`timescale 1ns/1ns
module tsn_target_test;
    import tsn_pkg::*;
    localparam int CMT = 20;
    localparam int CNV = 100;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        sel_hi = 1'b0;
    logic        sel_mid = 1'b0;
    logic        sel_lo = 1'b0;
    logic [11:0] adc = 12'h000;
    wire         scl;
    wire         sda_low;
    wire         sda_oe;
    wire         conv_active;
    wire         commit_busy;
    wire         sda = ~(sda_oe | sda_low);
    int          err_count = 0;
    int          n_compared = 0;
    int          seed = 32'hef23;
    logic [31:0] rnd;
    logic        m_single = CFG_SINGLE_RST;
    logic        m_done = 1'b1;
    logic [15:0] m_temp = TEMP_RST;
    logic [15:0] v;
    logic        a;

    tsn_target #(.COMMIT_COUNT(CMT), .CONV_COUNT(CNV)) u_tsn_target (
        .clk(clk), .rst_b(rst_b), .scl_clk(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .select_pin_hi(sel_hi), .select_pin_mid(sel_mid), .select_pin_lo(sel_lo),
        .adc_sample(adc), .conv_active(conv_active), .commit_busy(commit_busy));
    tsn_master_model u_tsn_master_model (.scl(scl), .sda_low(sda_low), .sda(sda));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic ctl(input logic [7:0] b, input logic exp_ack);
        u_tsn_master_model.wbyte(b, a);
        check(a, exp_ack);
    endtask
    task automatic cmd(input logic [7:0] c, input int nd, input logic [7:0] d);
        u_tsn_master_model.start();
        ctl({TYPE_CODE, sel_hi, sel_mid, sel_lo, 1'b0}, 1'b1);
        u_tsn_master_model.wbyte(c, a);
        check(a, 1'b1);
        if (nd > 0) begin
            u_tsn_master_model.wbyte(d, a);
            check(a, 1'b1);
        end
    endtask
    task automatic wr(input logic [7:0] c, input int nd, input logic [7:0] d);
        cmd(c, nd, d);
        u_tsn_master_model.stop(a);
    endtask
    task automatic rd(input logic [7:0] c, input int n, output logic [15:0] r);
        logic [7:0] b;
        cmd(c, 0, 8'h00);
        u_tsn_master_model.start();
        ctl({TYPE_CODE, sel_hi, sel_mid, sel_lo, 1'b1}, 1'b1);
        r = 16'h0000;
        for (int i = 0; i < n; i++) begin
            u_tsn_master_model.rbyte(i < n - 1, b);
            r = {r[7:0], b};
        end
        u_tsn_master_model.stop(a);
        check(a, 1'b1);
    endtask
    // Bounded wait for commit_busy (w = 0) or conv_active (w = 1) to reach a level
    task automatic wait_for(input int w, input logic lvl, input int lim);
        int k = 0;
        while ((w ? conv_active : commit_busy) !== lvl && k < lim) begin
            @(posedge clk);
            #2;
            k++;
        end
        check(k < lim, 1'b1);
    endtask
    task automatic new_adc();
        @(posedge clk);
        #2;
        rnd = $random(seed);
        adc = rnd[11:0];
    endtask
    task automatic cfg_write(input logic s);
        m_single = s;
        wr(CMD_ACCESS_CFG, 1, {7'h00, s});
        wait_for(0, 1'b1, 10);
        wait_for(0, 1'b0, CMT + 10);
        rd(CMD_ACCESS_CFG, 1, v);
        check(v, {m_done, CFG_FIXED, m_single});
    endtask

    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        #2_000_000;
        err_count++;
        stop_test();
    end
    initial begin
        rnd = $random(seed);
        {sel_hi, sel_mid, sel_lo} = rnd[2:0];
        repeat (16) @(posedge clk);
        #2 rst_b = 1'b1;
        rd(CMD_ACCESS_CFG, 1, v);
        check(v, {m_done, CFG_FIXED, m_single});
        rd(CMD_READ_TEMP, 2, v);
        check(v, m_temp);
        $display("defaults test done");
        // Each type code bit and each select bit flipped in turn
        for (int i = 0; i < 7; i++) begin
            u_tsn_master_model.start();
            ctl({TYPE_CODE, sel_hi, sel_mid, sel_lo, 1'b0} ^ (8'h02 << i), 1'b0);
            u_tsn_master_model.stop(a);
            check(a, 1'b1);
        end
        $display("address test done");
        cfg_write(1'b1);
        new_adc();
        wr(CMD_START_CONV, 0, 8'h00);
        wait_for(1, 1'b1, 10);
        m_done = 1'b0;
        rd(CMD_ACCESS_CFG, 1, v);
        check(v, {m_done, CFG_FIXED, m_single});
        wait_for(1, 1'b0, CNV + 10);
        m_done = 1'b1;
        m_temp = {adc, 4'h0};
        rd(CMD_READ_TEMP, 2, v);
        check(v, m_temp);
        rd(CMD_READ_TEMP, 1, v);
        check(v[7:0], m_temp[15:8]);
        rd(CMD_ACCESS_CFG, 1, v);
        check(v, {m_done, CFG_FIXED, m_single});
        check(conv_active, 1'b0);
        $display("single conversion test done");
        cfg_write(1'b0);
        new_adc();
        wr(CMD_START_CONV, 0, 8'h00);
        wait_for(1, 1'b1, 10);
        repeat (2 * CNV) @(posedge clk);
        rd(CMD_ACCESS_CFG, 1, v);
        check(v, {1'b0, CFG_FIXED, m_single});
        wr(CMD_STOP_CONV, 0, 8'h00);
        repeat (CNV + 20) @(posedge clk);
        check(conv_active, 1'b0);
        m_temp = {adc, 4'h0};
        rd(CMD_READ_TEMP, 2, v);
        check(v, m_temp);
        rd(CMD_ACCESS_CFG, 1, v);
        check(v, {m_done, CFG_FIXED, m_single});
        $display("continuous conversion test done");
        stop_test();
    end
endmodule
